//--- sysbus_pkg.sv
// shared types and constants for the system bus master interface
// Functional notes
// - bus clock runs 9.8304 MHz, period 101.725 ns, duty 30-70 percent; code makes 80 ns (12.5 MHz) from the 40 ns system clock.
// - bus control keeps working when the bus clock slows, halts or single steps.
// - transfers are not locked to the bus clock; handshake speed sets duration.
// - holding master may do single or back-to-back transfers, up to 5 MB/s.
// - master drives sixteen active-low address lines; line F is the msb.
// - eight bidirectional active-low data lines; line 7 is the msb.
// - initialisation line returns every module to a defined state.
// - while priority input says higher master wants bus, suspend and release drivers.
// - bus-busy follows hold-acknowledge; busy keeps other masters off the bus.
// - memory read: address first, then memory-read command; memory drives data.
// - memory write: address and data before memory-write command; memory stores.
// - i/o read: port address then i/o-read command; port drives data.
// - i/o write: port address and data then i/o-write command; port takes data.
// - device supplies constant clock 9.8304 MHz, aligned with the bus clock; code gives it the bus clock's 80 ns (12.5 MHz).
// - no priority-request output; device shares bus with one master, lower priority.
// - priority input high lets device take bus; low keeps device off.
package sysbus_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// setup and hold of address and data around the command, in link clocks
	localparam logic [3:0] SETUP_CYC = 4'h1;
	localparam logic [3:0] HOLD_CYC  = 4'h1;
	localparam real BCLK_PERIOD_NS = 101.725;
	localparam real MCLK_PERIOD_NS = 40.0;
	localparam int BCLK_HALF_CYC = (int'(BCLK_PERIOD_NS / MCLK_PERIOD_NS) / 2 < 1) ? 1 :
		int'(BCLK_PERIOD_NS / MCLK_PERIOD_NS) / 2;
	localparam logic [1:0] OP_MEM_RD = 2'h0;
	localparam logic [1:0] OP_MEM_WR = 2'h1;
	localparam logic [1:0] OP_IO_RD  = 2'h2;
	localparam logic [1:0] OP_IO_WR  = 2'h3;

	typedef struct packed {
		logic [1:0]        op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} req_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              early;
	} rsp_t;
endpackage

//--- sysbus_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sysbus_sync #(
	parameter int          W        = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = d_i;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= RST_VAL;
			q_o    <= RST_VAL;
		end else begin
			meta_r <= meta_nxt;
			q_o    <= q_nxt;
		end
	end
endmodule // sysbus_sync
`default_nettype wire

//--- sysbus_clkgen.sv
// bus clock and constant clock generator from the system clock
`timescale 1ns/1ps
`default_nettype none
module sysbus_clkgen #(
	parameter int HALF_CYC = sysbus_pkg::BCLK_HALF_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	output var  logic bclk_n_o,
	output var  logic constant_clock_n_n_o
);
	localparam int CW = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          ph_r;
	logic          ph_nxt;

	initial begin
		if (HALF_CYC < 1) $error("HALF_CYC must be at least 1");
	end

	// 50 percent duty, inside the 30-70 limit; true rate is bounded by the system clock
	always_comb begin
		cnt_nxt = cnt_r + CW'(1);
		ph_nxt  = ph_r;
		if (cnt_r == CW'(HALF_CYC - 1)) begin
			cnt_nxt = '0;
			ph_nxt  = ~ph_r;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r    <= '0;
			ph_r     <= 1'b1;
			bclk_n_o <= 1'b1;
			constant_clock_n_n_o <= 1'b1;
		end else begin
			cnt_r    <= cnt_nxt;
			ph_r     <= ph_nxt;
			bclk_n_o <= ph_nxt;
			constant_clock_n_n_o <= ph_nxt;
		end
	end
endmodule // sysbus_clkgen
`default_nettype wire

//--- sysbus_master.sv
// system bus master: request handshake on the system clock, bus cycles on the link clock
`timescale 1ns/1ps
`default_nettype none
module sysbus_master (
	input  wire logic                            MCLK_I,
	input  wire logic                            RST_B_I,
	input  wire logic                            LINK_CLK_I,
	// user side
	input  wire logic                            REQ_VALID_I,
	input  wire sysbus_pkg::req_t                REQ_I,
	output var  logic                            REQ_READY_O,
	output var  logic                            RSP_VALID_O,
	output var  sysbus_pkg::rsp_t                RSP_O,
	output var  logic                            SUSPENDED_O,
	output var  logic                            EXT_IRQ_O,
	// bus side
	input  wire logic                            INIT_N_I,
	input  wire logic                            BUS_PRIORITY_IN_N_I,
	input  wire logic                            HOLD_REQ_N_I,
	output var  logic                            BUS_GRANT_OUT_N_O,
	output var  logic                            BUSY_N_O,
	output var  logic                            BUSY_OE_O,
	output var  logic [sysbus_pkg::ADDR_W-1:0]   ADDRESS_LINES_N_O,
	output var  logic                            ADDRESS_OE_O,
	input  wire logic [sysbus_pkg::DATA_W-1:0]   DATA_LINES_N_I,
	output var  logic [sysbus_pkg::DATA_W-1:0]   DATA_LINES_N_O,
	output var  logic                            DATA_OE_O,
	output var  logic                            MEM_READ_CMD_N_O,
	output var  logic                            MEM_WRITE_CMD_N_O,
	output var  logic                            IO_READ_CMD_N_O,
	output var  logic                            IO_WRITE_CMD_N_O,
	output var  logic                            CMD_OE_O,
	input  wire logic                            TRANSFER_ACK_N_I,
	input  wire logic                            EARLY_READ_ACK_N_I,
	input  wire logic                            EXTERNAL_IRQ_N_I,
	output var  logic                            BCLK_N_O,
	output var  logic                            CONSTANT_CLOCK_N_O
);
	typedef enum logic [2:0] {L_IDLE, L_SETUP, L_CMD, L_HOLD} lstate_t;

	// ---- system clock domain ----
	logic        init_s;
	logic        ack_tgl_s;
	logic        pri_s;
	logic        irq_s;
	logic        hold_s;
	logic        req_tgl_r,  req_tgl_nxt;
	logic        busy_r,     busy_nxt;
	logic        ack_seen_r, ack_seen_nxt;
	sysbus_pkg::req_t req_r, req_nxt;
	logic        rsp_valid_nxt;
	logic        ack_tgl_r;

	// toggle bit resets to the link side's reset value so no false change follows reset
	sysbus_sync #(.W(5), .RST_VAL(5'h1e)) u_sync_m (
		.clk_i   (MCLK_I),
		.rst_b_i (RST_B_I),
		.d_i     ({INIT_N_I, BUS_PRIORITY_IN_N_I, EXTERNAL_IRQ_N_I, HOLD_REQ_N_I, ack_tgl_r}),
		.q_o     ({init_s, pri_s, irq_s, hold_s, ack_tgl_s})
	);

	sysbus_clkgen u_clkgen (
		.clk_i    (MCLK_I),
		.rst_b_i  (RST_B_I),
		.bclk_n_o (BCLK_N_O),
		.constant_clock_n_n_o (CONSTANT_CLOCK_N_O)
	);

	// one request in flight; the toggle pair carries it across and back
	always_comb begin
		req_tgl_nxt   = req_tgl_r;
		busy_nxt      = busy_r;
		req_nxt       = req_r;
		ack_seen_nxt  = ack_tgl_s;
		rsp_valid_nxt = 1'b0;
		if (!init_s) begin
			// an aborted request still answers, so the user side never waits forever
			busy_nxt      = 1'b0;
			rsp_valid_nxt = busy_r;
		end else if (!busy_r && REQ_VALID_I) begin
			req_nxt     = REQ_I;
			req_tgl_nxt = ~req_tgl_r;
			busy_nxt    = 1'b1;
		end else if (busy_r && (ack_tgl_s != ack_seen_r)) begin
			busy_nxt      = 1'b0;
			rsp_valid_nxt = 1'b1;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			req_tgl_r   <= 1'b0;
			busy_r      <= 1'b0;
			ack_seen_r  <= 1'b0;
			req_r       <= '0;
			REQ_READY_O <= 1'b0;
			RSP_VALID_O <= 1'b0;
			SUSPENDED_O <= 1'b0;
			EXT_IRQ_O   <= 1'b0;
			BUS_GRANT_OUT_N_O <= 1'b1;
			BUSY_N_O    <= 1'b1;
			BUSY_OE_O   <= 1'b0;
		end else begin
			req_tgl_r   <= req_tgl_nxt;
			busy_r      <= busy_nxt;
			ack_seen_r  <= ack_seen_nxt;
			req_r       <= req_nxt;
			REQ_READY_O <= ~busy_nxt & init_s;
			RSP_VALID_O <= rsp_valid_nxt;
			SUSPENDED_O <= ~pri_s;
			EXT_IRQ_O   <= ~irq_s;
			BUS_GRANT_OUT_N_O <= hold_s;
			BUSY_N_O    <= hold_s;
			BUSY_OE_O   <= ~hold_s;
		end
	end

	// ---- link clock domain ----
	logic        rst_l_b;
	logic        init_l, pri_l, req_tgl_l, transfer_ack_n_l, early_read_ack_n_l;
	lstate_t     ls_r, ls_nxt;
	logic [3:0]  lcnt_r, lcnt_nxt;
	logic        ack_tgl_nxt;
	logic        req_seen_r, req_seen_nxt;
	logic        cmd_r, cmd_nxt;
	logic        drive_r, drive_nxt;
	sysbus_pkg::rsp_t rsp_l_r, rsp_l_nxt;

	assign rst_l_b = RST_B_I;

	// link clock may stall; every step just waits on the next edge
	sysbus_sync #(.W(5), .RST_VAL(5'h1b)) u_sync_l (
		.clk_i   (LINK_CLK_I),
		.rst_b_i (rst_l_b),
		.d_i     ({INIT_N_I, BUS_PRIORITY_IN_N_I, req_tgl_r, TRANSFER_ACK_N_I, EARLY_READ_ACK_N_I}),
		.q_o     ({init_l, pri_l, req_tgl_l, transfer_ack_n_l, early_read_ack_n_l})
	);

	// command length set by the handshake; setup and hold are fixed link-clock counts
	always_comb begin
		ls_nxt       = ls_r;
		lcnt_nxt     = lcnt_r;
		ack_tgl_nxt  = ack_tgl_r;
		req_seen_nxt = req_seen_r;
		cmd_nxt      = cmd_r;
		drive_nxt    = drive_r;
		rsp_l_nxt    = rsp_l_r;
		case (ls_r)
			L_IDLE: begin
				// lower priority: only start while the other master leaves its request high
				if (init_l && pri_l && (req_tgl_l != req_seen_r)) begin
					req_seen_nxt = req_tgl_l;
					drive_nxt    = 1'b1;
					lcnt_nxt     = sysbus_pkg::SETUP_CYC;
					ls_nxt       = L_SETUP;
				end
			end
			L_SETUP: begin
				if (lcnt_r > 4'h1) begin
					lcnt_nxt = lcnt_r - 4'h1;
				end else begin
					cmd_nxt = 1'b1;
					ls_nxt  = L_CMD;
				end
			end
			L_CMD: begin
				// command held until transfer acknowledge, or early read acknowledge on reads
				if (!transfer_ack_n_l || (!early_read_ack_n_l && !req_r.op[0])) begin
					rsp_l_nxt.rdata = ~DATA_LINES_N_I;
					rsp_l_nxt.early = transfer_ack_n_l;
					cmd_nxt  = 1'b0;
					lcnt_nxt = sysbus_pkg::HOLD_CYC;
					ls_nxt   = L_HOLD;
				end
			end
			L_HOLD: begin
				if (lcnt_r > 4'h1) begin
					lcnt_nxt = lcnt_r - 4'h1;
				end else begin
					drive_nxt   = 1'b0;
					ack_tgl_nxt = ~ack_tgl_r; // back-to-back allowed next idle
					ls_nxt      = L_IDLE;
				end
			end
			default: ls_nxt = L_IDLE;
		endcase
		if (!init_l || !pri_l) begin
			cmd_nxt   = 1'b0;
			drive_nxt = 1'b0;
			if (ls_r != L_IDLE) begin
				ack_tgl_nxt = ~ack_tgl_r;
			end
			ls_nxt    = L_IDLE;
		end
	end

	always_ff @(posedge LINK_CLK_I or negedge rst_l_b) begin
		if (!rst_l_b) begin
			ls_r       <= L_IDLE;
			lcnt_r     <= '0;
			ack_tgl_r  <= 1'b0;
			req_seen_r <= 1'b0;
			cmd_r      <= 1'b0;
			drive_r    <= 1'b0;
			rsp_l_r    <= '0;
		end else begin
			ls_r       <= ls_nxt;
			lcnt_r     <= lcnt_nxt;
			ack_tgl_r  <= ack_tgl_nxt;
			req_seen_r <= req_seen_nxt;
			cmd_r      <= cmd_nxt;
			drive_r    <= drive_nxt;
			rsp_l_r    <= rsp_l_nxt;
		end
	end

	// req_r is stable while a request is in flight, so the link side may read it directly
	always_ff @(posedge LINK_CLK_I or negedge rst_l_b) begin
		if (!rst_l_b) begin
			ADDRESS_LINES_N_O <= '1;
			ADDRESS_OE_O      <= 1'b0;
			DATA_LINES_N_O    <= '1;
			DATA_OE_O         <= 1'b0;
			MEM_READ_CMD_N_O  <= 1'b1;
			MEM_WRITE_CMD_N_O <= 1'b1;
			IO_READ_CMD_N_O   <= 1'b1;
			IO_WRITE_CMD_N_O  <= 1'b1;
			CMD_OE_O          <= 1'b0;
		end else begin
			ADDRESS_LINES_N_O <= ~req_r.addr;
			ADDRESS_OE_O      <= drive_nxt;
			DATA_LINES_N_O    <= ~req_r.wdata;
			DATA_OE_O         <= drive_nxt & req_r.op[0];
			MEM_READ_CMD_N_O  <= ~(cmd_nxt && req_r.op == sysbus_pkg::OP_MEM_RD);
			MEM_WRITE_CMD_N_O <= ~(cmd_nxt && req_r.op == sysbus_pkg::OP_MEM_WR);
			IO_READ_CMD_N_O   <= ~(cmd_nxt && req_r.op == sysbus_pkg::OP_IO_RD);
			IO_WRITE_CMD_N_O  <= ~(cmd_nxt && req_r.op == sysbus_pkg::OP_IO_WR);
			CMD_OE_O          <= drive_nxt;
		end
	end

	// read data captured in link domain is stable by the time the toggle lands
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			RSP_O <= '0;
		end else begin
			RSP_O <= rsp_valid_nxt ? rsp_l_r : RSP_O;
		end
	end

	a_cmd_needs_addr: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		!MEM_READ_CMD_N_O |-> ADDRESS_OE_O) else $error("command without address drive");
	a_wr_data_first: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		$fell(MEM_WRITE_CMD_N_O) |-> $past(DATA_OE_O)) else $error("write command before data");
	a_iow_data_first: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		$fell(IO_WRITE_CMD_N_O) |-> $past(DATA_OE_O)) else $error("io write before data");
	a_ior_addr_first: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		$fell(IO_READ_CMD_N_O) |-> $past(ADDRESS_OE_O)) else $error("io read before address");
	a_cmd_held_ack: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		(ls_r == L_CMD && transfer_ack_n_l && early_read_ack_n_l && init_l && pri_l) |=> (ls_r == L_CMD)) else $error("command dropped");
	a_yield_prio: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		!pri_l |=> !ADDRESS_OE_O && !CMD_OE_O) else $error("drivers on while yielded");
	a_init_idle: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		!init_l |=> ls_r == L_IDLE) else $error("init did not idle");
	a_busy_grant: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		BUSY_N_O == BUS_GRANT_OUT_N_O) else $error("busy not tied to grant");
	a_one_cmd: assert property (@(posedge LINK_CLK_I) disable iff (!rst_l_b)
		$onehot0(~{MEM_READ_CMD_N_O, MEM_WRITE_CMD_N_O, IO_READ_CMD_N_O, IO_WRITE_CMD_N_O}))
		else $error("two commands at once");

	c_mem_read: cover property (@(posedge LINK_CLK_I) $fell(MEM_READ_CMD_N_O));
	c_io_write: cover property (@(posedge LINK_CLK_I) $fell(IO_WRITE_CMD_N_O));
	c_early_ack: cover property (@(posedge LINK_CLK_I) ls_r == L_CMD && !early_read_ack_n_l && transfer_ack_n_l);
	c_yield: cover property (@(posedge LINK_CLK_I) ls_r != L_IDLE && !pri_l);
endmodule // sysbus_master
`default_nettype wire

//--- sysbus_slave_model.sv
// behavioural memory and i/o slave on the far side of the bus master
`timescale 1ns/1ps
`default_nettype none
module sysbus_slave_model (
	input  wire logic        link_clk_i,
	input  wire logic [15:0] addr_n_i,
	input  wire logic [7:0]  wdata_n_i,
	input  wire logic [3:0]  cmd_n_i,
	input  wire logic        cmd_oe_i,
	input  wire logic [7:0]  ack_dly_i,
	input  wire logic        early_i,
	output var  logic [7:0]  data_n_o,
	output var  logic        ack_n_o,
	output var  logic        early_n_o
);
	// cmd_n_i order: memory read, memory write, i/o read, i/o write
	logic [7:0] mem [0:65535];
	logic [7:0] io  [0:65535];
	logic [7:0] cnt = 8'h00;

	initial begin
		data_n_o = 8'h00;
		ack_n_o = 1'b1;
		early_n_o = 1'b1;
	end

	always @(posedge link_clk_i) begin
		if (!cmd_oe_i || cmd_n_i == 4'hf) begin
			cnt <= 8'h00;
			ack_n_o <= 1'b1;
			early_n_o <= 1'b1;
			// released lines float: show a pattern that changes every cycle
			data_n_o <= ~data_n_o;
		end else begin
			if (cnt != ack_dly_i) begin
				cnt <= cnt + 8'h01;
				data_n_o <= ~data_n_o;
			end
			if (!cmd_n_i[3] && early_i) begin
				early_n_o <= 1'b0;
				data_n_o <= ~mem[~addr_n_i];
			end
			if (cnt == ack_dly_i) begin
				ack_n_o <= 1'b0;
				if (!cmd_n_i[2]) mem[~addr_n_i] <= ~wdata_n_i;
				if (!cmd_n_i[0]) io[~addr_n_i] <= ~wdata_n_i;
				if (!cmd_n_i[3]) data_n_o <= ~mem[~addr_n_i];
				if (!cmd_n_i[1]) data_n_o <= ~io[~addr_n_i];
			end
		end
	end
endmodule // sysbus_slave_model
`default_nettype wire

//--- system_bus_master_interface_bench.sv
// self-checking bench of the system bus master against the slave model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); fail_count++; end end
module system_bus_master_interface_bench;
	logic              mclk = 1'b0;
	logic              lclk = 1'b0;
	logic              rst_b = 1'b0;
	logic              req_valid = 1'b0;
	sysbus_pkg::req_t  req = '0;
	logic              init_n = 1'b1;
	logic              prio_n = 1'b1;
	logic              hold_n = 1'b1;
	logic              irq_n = 1'b1;
	logic [7:0]        ack_dly = 8'h00;
	logic              use_early = 1'b0;
	wire               ready, rsp_valid, susp, irq, grant_n, busy_n, busy_oe, aoe, doe, cmd_oe;
	wire               ack_n, early_n, bclk_n, constant_clock_n_n;
	wire sysbus_pkg::rsp_t rsp;
	wire [15:0]        addr_n;
	wire [7:0]         dout_n, slv_data, data_bus;
	wire [3:0]         cmd_n;
	int                fail_count = 0;
	int                total_checks = 0;
	int                low_len = 0;
	int                clk_diff = 0;
	int                clk_edges = 0;
	logic [3:0]        s_cmd;
	logic [15:0]       s_addr;
	logic [7:0]        s_data;
	logic              s_doe, s_setup, prev_aoe, addr_moved, last_b;

	always #20 mclk = ~mclk;
	always #32 lclk = ~lclk;
	// the master drives the data lines only while enabled; otherwise the slave owns them
	assign data_bus = doe ? dout_n : slv_data;

	sysbus_master u_dut (.MCLK_I(mclk), .RST_B_I(rst_b), .LINK_CLK_I(lclk), .REQ_VALID_I(req_valid),
		.REQ_I(req), .REQ_READY_O(ready), .RSP_VALID_O(rsp_valid), .RSP_O(rsp), .SUSPENDED_O(susp),
		.EXT_IRQ_O(irq), .INIT_N_I(init_n), .BUS_PRIORITY_IN_N_I(prio_n), .HOLD_REQ_N_I(hold_n),
		.BUS_GRANT_OUT_N_O(grant_n), .BUSY_N_O(busy_n), .BUSY_OE_O(busy_oe), .ADDRESS_LINES_N_O(addr_n),
		.ADDRESS_OE_O(aoe), .DATA_LINES_N_I(data_bus), .DATA_LINES_N_O(dout_n), .DATA_OE_O(doe),
		.MEM_READ_CMD_N_O(cmd_n[3]), .MEM_WRITE_CMD_N_O(cmd_n[2]), .IO_READ_CMD_N_O(cmd_n[1]),
		.IO_WRITE_CMD_N_O(cmd_n[0]), .CMD_OE_O(cmd_oe), .TRANSFER_ACK_N_I(ack_n),
		.EARLY_READ_ACK_N_I(early_n), .EXTERNAL_IRQ_N_I(irq_n), .BCLK_N_O(bclk_n),
		.CONSTANT_CLOCK_N_O(constant_clock_n_n));

	sysbus_slave_model u_slave (.link_clk_i(lclk), .addr_n_i(addr_n), .wdata_n_i(data_bus), .cmd_n_i(cmd_n),
		.cmd_oe_i(cmd_oe), .ack_dly_i(ack_dly), .early_i(use_early), .data_n_o(slv_data), .ack_n_o(ack_n),
		.early_n_o(early_n));

	// snapshot of the bus at the first cycle of each command
	always @(posedge lclk) begin
		prev_aoe <= aoe;
		if (cmd_oe && cmd_n != 4'hf) begin
			if (low_len == 0) begin
				s_cmd <= cmd_n;
				s_addr <= addr_n;
				s_data <= data_bus;
				s_doe <= doe;
				s_setup <= prev_aoe;
			end else if (addr_n !== s_addr) begin
				addr_moved <= 1'b1;
			end
			low_len <= low_len + 1;
		end
	end

	always @(posedge mclk) begin
		if (rst_b) begin
			if (bclk_n !== constant_clock_n_n) clk_diff++;
			if (bclk_n !== last_b) clk_edges++;
		end
		last_b <= bclk_n;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wait_rsp(output bit got);
		got = 0;
		for (int i = 0; i < 400 && !got; i++) begin
			@(posedge mclk);
			got = (rsp_valid === 1'b1);
		end
	endtask

	task automatic issue(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
		addr_moved = 1'b0;
		low_len = 0;
		for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge mclk);
		req <= '{op, a, d};
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
	endtask

	task automatic xfer(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d, input logic [7:0] dly,
		input logic e);
		bit got;
		ack_dly <= dly;
		use_early <= e;
		issue(op, a, d);
		wait_rsp(got);
		`CHK("response", 1'b1, got)
		`CHK("command", ~(4'h8 >> op), s_cmd)
		`CHK("address", ~a, s_addr)
		`CHK("addr setup", 1'b1, s_setup)
		`CHK("addr steady", 1'b0, addr_moved)
		`CHK("write drive", op[0], s_doe)
		if (op[0]) `CHK("wdata", ~d, s_data)
		if (!e) `CHK("cmd until ack", 1'b1, low_len > dly)
	endtask

	task automatic hold_test();
		hold_n <= 1'b0;
		tick(10);
		`CHK("grant", 1'b0, grant_n)
		`CHK("busy", 1'b0, busy_n)
		`CHK("busy drive", 1'b1, busy_oe)
		hold_n <= 1'b1;
		tick(10);
		`CHK("grant off", 1'b1, grant_n)
		`CHK("busy free", 1'b0, busy_oe)
	endtask

	task automatic prio_test();
		prio_n <= 1'b0;
		tick(10);
		`CHK("suspended", 1'b1, susp)
		`CHK("addr released", 1'b0, aoe)
		`CHK("cmd released", 1'b0, cmd_oe)
		prio_n <= 1'b1;
		tick(10);
		`CHK("resumed", 1'b0, susp)
	endtask

	// slow slave, then priority loss or initialisation in mid-cycle
	task automatic abort_test(input bit by_init);
		bit got;
		ack_dly <= 8'hc8;
		use_early <= 1'b0;
		issue(sysbus_pkg::OP_MEM_RD, 16'h1234, 8'h00);
		for (int i = 0; i < 100 && low_len == 0; i++) @(posedge mclk);
		if (by_init) init_n <= 1'b0;
		else prio_n <= 1'b0;
		wait_rsp(got);
		`CHK("abort end", 1'b1, got)
		tick(4);
		`CHK("abort cmd", 1'b0, cmd_oe)
		`CHK("abort addr", 1'b0, aoe)
		if (by_init) `CHK("init ready", 1'b0, ready)
		init_n <= 1'b1;
		prio_n <= 1'b1;
		tick(10);
		`CHK("ready again", 1'b1, ready)
	endtask

	task automatic irq_test();
		irq_n <= 1'b0;
		tick(6);
		`CHK("irq", 1'b1, irq)
		irq_n <= 1'b1;
		tick(6);
		`CHK("irq clear", 1'b0, irq)
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		tick(4);
		xfer(sysbus_pkg::OP_MEM_WR, 16'hffff, 8'ha5, 8'h02, 1'b0);
		xfer(sysbus_pkg::OP_MEM_RD, 16'hffff, 8'h00, 8'h06, 1'b0);
		`CHK("mem rdata", 8'ha5, rsp.rdata)
		`CHK("normal end", 1'b0, rsp.early)
		xfer(sysbus_pkg::OP_IO_WR, 16'h0000, 8'h3c, 8'h00, 1'b0);
		xfer(sysbus_pkg::OP_IO_RD, 16'h0000, 8'h00, 8'h04, 1'b0);
		`CHK("io rdata", 8'h3c, rsp.rdata)
		xfer(sysbus_pkg::OP_MEM_WR, 16'h0001, 8'h5a, 8'h01, 1'b0);
		xfer(sysbus_pkg::OP_MEM_RD, 16'h0001, 8'h00, 8'h0a, 1'b1);
		`CHK("early rdata", 8'h5a, rsp.rdata)
		`CHK("early flag", 1'b1, rsp.early)
		hold_test();
		prio_test();
		abort_test(1'b0);
		abort_test(1'b1);
		irq_test();
		`CHK("clock pair", 0, clk_diff)
		`CHK("clock runs", 1'b1, clk_edges > 100)
		print_verdict();
	end

	// the run takes a few hundred system clock cycles; this bound leaves a wide margin
	initial begin
		#2000000;
		fail_count++;
		print_verdict();
	end
endmodule // system_bus_master_interface_bench
`default_nettype wire
